/* bench/zcd_analog_model.sv */
// Behavioural model of the analog current source and sink stage
`timescale 1ns/1ps
module zcd_analog_model (
	input  wire logic ref_clk,
	input  wire logic level,
	input  wire logic toggle,
	output logic      sinkActive
);
	initial sinkActive = 1'b0;
	// Fast mode flips every cycle, the worst a chattering crossing can present
	always @(posedge ref_clk) begin
		sinkActive <= toggle ? ~sinkActive : level;
	end
endmodule // zcd_analog_model

/* bench/zcd_logic_asserts.sv */
// Concurrent checks on the zero-cross logic ports
`timescale 1ns/1ps
module zcd_logic_asserts (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        sinkActive,
	input wire logic        configFuse,
	input wire logic        detectorEnable,
	input wire logic        pinForceAnalog,
	input wire logic        zeroCrossOut,
	input wire logic        crossingIrq
);
	logic [3:0] quiet;
	logic       sinkPrev;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Cycles since the analog side or software last disturbed the output path
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			quiet    <= 4'h0;
			sinkPrev <= 1'b0;
		end else begin
			sinkPrev <= sinkActive;
			quiet    <= (sinkActive != sinkPrev || avs_write) ? 4'h0 : (quiet == 4'hf ? quiet : quiet + 4'h1);
		end
	end
	a_wait_ack: assert property (
		(avs_read || avs_write) && avs_waitrequest && $past(avs_waitrequest) |=> !avs_waitrequest)
		else $error("bus request not answered after one wait cycle");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("waitrequest low without a request");
	a_read_upper: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h0)
		else $error("read data not zero extended");
	a_fuse_hold: assert property (!configFuse && detectorEnable |=> detectorEnable)
		else $error("detector disabled while fuse is clear");
	a_pin_follow: assert property ($stable(detectorEnable)[*2] |-> pinForceAnalog == detectorEnable)
		else $error("pin function does not follow detector enable");
	a_irq_fall: assert property ($fell(crossingIrq) |-> quiet < 4'h4)
		else $error("interrupt dropped without a software write");
	a_irq_cause: assert property ($rose(crossingIrq) |-> quiet < 4'h8)
		else $error("interrupt raised without an edge or write");
	a_out_quiet: assert property (quiet >= 4'h8 |-> $stable(zeroCrossOut))
		else $error("output moved with a steady analog input");
endmodule // zcd_logic_asserts
bind zcd_logic zcd_logic_asserts u_asserts (.ref_clk, .rst_n, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .sinkActive, .configFuse, .detectorEnable, .pinForceAnalog, .zeroCrossOut, .crossingIrq);

/* bench/zcd_logic_tb_top.sv */
// Self-checking bench for the zero-cross logic
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errCount++; $display("mismatch %s exp %h got %h", n, e, s); end end
module zcd_logic_tb_top;
	import zcd_pkg::*;
	localparam logic [7:0] EC [7] = '{8'h02, 8'h02, 8'h01, 8'h01, 8'h12, 8'h11, 8'h01};
	localparam logic [6:0] ES = 7'h65;
	localparam logic [6:0] EF = 7'h39;
	localparam logic [ZCD_ADDR_W-1:0] CA = ZCD_CONTROL_ADDR, SA = ZCD_IRQ_STATUS_ADDR, XA = ZCD_IRQ_CLEAR_ADDR;
	localparam logic [ZCD_ADDR_W-1:0] EA = ZCD_IRQ_ENABLE_ADDR, MA = ZCD_MODULE_CTRL_ADDR;
	logic                  ref_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic                  configFuse = 1'b0, sleepMode = 1'b0, lvl = 1'b0, tog = 1'b0;
	logic [ZCD_ADDR_W-1:0] avs_address = 18'h0;
	logic [31:0]           avs_writedata = 32'h0, avs_readdata, rdData;
	logic                  avs_waitrequest, sinkActive, detectorEnable, pinForceAnalog, zeroCrossOut, crossingIrq;
	int                    errCount = 0, compares = 0, cyc = 0;
	zcd_logic dut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .sinkActive, .configFuse, .sleepMode, .detectorEnable, .pinForceAnalog,
		.zeroCrossOut, .crossingIrq);
	zcd_analog_model partner (.ref_clk, .level(lvl), .toggle(tog), .sinkActive);
	initial forever #2.5 ref_clk = ~ref_clk;
	task automatic endSim;
		if (errCount == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errCount++;
			endSim;
		end
	end
	task automatic bus(input logic w, input logic [ZCD_ADDR_W-1:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rdData = avs_readdata;
		if (n >= 50) errCount++;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [ZCD_ADDR_W-1:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input string n, input logic [ZCD_ADDR_W-1:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(n, e, rdData)
	endtask
	task automatic wt;
		repeat (10) @(posedge ref_clk);
	endtask
	task automatic rstDut(input logic f);
		rst_n <= 1'b0;
		configFuse <= f;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic tRegs;
		rd("ctrl", CA, 32'h0);
		rd("unmapped", 18'h10, 32'h0);
		`CHK("detEn", 1'b1, detectorEnable)
		wr(CA, 32'hff);
		wt;
		rd("ctrl", CA, 32'hb3);
		wr(CA, 32'h0);
		wt;
		wr(XA, 32'h1);
		rd("clear", XA, 32'h0);
		rd("stat", SA, 32'h0);
	endtask
	task automatic tPolarity;
		for (int i = 0; i < 4; i++) begin
			wr(CA, {27'h0, i[1], 4'h0});
			lvl <= i[0];
			wt;
			rd("out", CA, {26'h0, i[0] ^ i[1], i[1], 4'h0});
			`CHK("zcOut", i[0] ^ i[1], zeroCrossOut)
		end
		rd("stat", SA, 32'h0);
	endtask
	task automatic tEdges;
		lvl <= 1'b0;
		sleepMode <= 1'b1;
		wr(CA, 32'h0);
		wr(EA, 32'h1);
		rd("irqEn", EA, 32'h1);
		wt;
		wr(XA, 32'h1);
		for (int i = 0; i < 7; i++) begin
			wr(CA, {24'h0, EC[i]});
			lvl <= ES[i];
			wt;
			rd("flag", SA, {31'h0, EF[i]});
			`CHK("irq", EF[i], crossingIrq)
			wr(XA, 32'h1);
			wt;
		end
		wr(EA, 32'h0);
		lvl <= 1'b0;
		wt;
		rd("flag", SA, 32'h1);
		`CHK("irq", 1'b0, crossingIrq)
		wr(EA, 32'h1);
		wt;
		`CHK("irq", 1'b1, crossingIrq)
		wr(CA, 32'h3);
		tog <= 1'b1;
		wt;
		wr(XA, 32'h1);
		rd("flag", SA, 32'h1);
		tog <= 1'b0;
		sleepMode <= 1'b0;
		wt;
		wr(XA, 32'h1);
		wt;
		`CHK("irq", 1'b0, crossingIrq)
		// Edge flags one cycle before the clear strobe, so the clear removes it
		lvl <= 1'b1;
		repeat (3) @(posedge ref_clk);
		wr(XA, 32'h1);
		wt;
		rd("flag", SA, 32'h0);
		// Edge flags on the very clear strobe, so the set has to win
		lvl <= 1'b0;
		repeat (2) @(posedge ref_clk);
		wr(XA, 32'h1);
		wt;
		rd("flag", SA, 32'h1);
		`CHK("irq", 1'b1, crossingIrq)
	endtask
	task automatic tFuse;
		rstDut(1'b1);
		`CHK("detEn", 1'b0, detectorEnable)
		`CHK("pin", 1'b0, pinForceAnalog)
		wr(CA, 32'h80);
		wt;
		`CHK("detEn", 1'b1, detectorEnable)
		`CHK("pin", 1'b1, pinForceAnalog)
		wr(MA, 32'h1);
		rd("modDis", MA, 32'h1);
		wt;
		`CHK("detEn", 1'b0, detectorEnable)
		wr(MA, 32'h0);
		wr(CA, 32'h0);
		wt;
		`CHK("detEn", 1'b0, detectorEnable)
		rstDut(1'b0);
		wr(MA, 32'h1);
		wt;
		`CHK("detEn", 1'b1, detectorEnable)
	endtask
	initial begin
		rstDut(1'b0);
		tRegs;
		tPolarity;
		tEdges;
		tFuse;
		endSim;
	end
endmodule // zcd_logic_tb_top

/* hw/zcd_edge_detect.sv */
// Synchroniser, polarity inversion and edge detection for the analog sink indication
`timescale 1ns/1ps
module zcd_edge_detect
	import zcd_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rstSyncN,
	input  wire logic sinkActive,
	input  wire logic invertSelect,
	output logic      logicOut,
	output logic      risePulse,
	output logic      fallPulse
);

	logic [1:0] syncChain;
	logic       prevOut;
	logic       next_logicOut;

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			syncChain <= ZCD_SYNC_RESET;
		end else begin
			syncChain <= {syncChain[0], sinkActive};
		end
	end

	// Sink gives 1 before inversion; inverted it reads 1 while sourcing
	assign next_logicOut = syncChain[1] ^ invertSelect;

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			logicOut <= 1'b0;
			prevOut  <= 1'b0;
		end else begin
			logicOut <= next_logicOut;
			prevOut  <= logicOut;
		end
	end

	// Edges seen after inversion, so a polarity flip alone makes an edge
	assign risePulse = logicOut & ~prevOut;
	assign fallPulse = ~logicOut & prevOut;

endmodule // zcd_edge_detect

/* hw/zcd_logic.sv */
// Zero-cross detector digital side: control register, edge flagging, interrupt, Avalon-MM slave
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module zcd_logic
	import zcd_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic [ZCD_ADDR_W-1:0] avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	input  wire logic                  sinkActive,
	input  wire logic                  configFuse,
	input  wire logic                  sleepMode,
	output logic                       detectorEnable,
	output logic                       pinForceAnalog,
	output logic                       zeroCrossOut,
	output logic                       crossingIrq
);

	zcd_av_req_s    busReq;
	zcd_av_rsp_s    busRsp;
	zcd_ctrl_s      ctrl;
	zcd_bus_state_e busState;
	logic [1:0]     rstSync;
	logic           rstSyncN;
	logic           moduleDisable;
	logic           crossingFlag;
	logic           crossingIrqEnable;
	logic           logicOut;
	logic           risePulse;
	logic           fallPulse;
	logic           edgeEvent;
	logic           wrStrobe;
	logic           clearHit;
	logic           next_detectorEnable;
	logic [31:0]    next_readdata;
	logic           ctrlSel;
	logic           statusSel;
	logic           clearSel;
	logic           enableSel;
	logic           moduleSel;

	assign busReq = '{address: avs_address, read: avs_read, write: avs_write, writedata: avs_writedata};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync <= ZCD_SYNC_RESET;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstSyncN = rstSync[1];

	zcd_edge_detect u_edge (
		.ref_clk      (ref_clk),
		.rstSyncN     (rstSyncN),
		.sinkActive   (sinkActive),
		.invertSelect (ctrl.invertSelect),
		.logicOut     (logicOut),
		.risePulse    (risePulse),
		.fallPulse    (fallPulse)
	);

	// Each access answers one cycle after it is seen, then idles one cycle
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			busState <= ZCD_BUS_IDLE;
		end else begin
			case (busState)
				ZCD_BUS_IDLE: begin
					if (busReq.read || busReq.write) begin
						busState <= ZCD_BUS_ACK;
					end
				end
				ZCD_BUS_ACK: begin
					busState <= ZCD_BUS_IDLE;
				end
				default: begin
					busState <= ZCD_BUS_IDLE;
				end
			endcase
		end
	end

	// One select per register; an unmapped address selects nothing, so writes there are dropped
	always_comb begin
		ctrlSel   = 1'b0;
		statusSel = 1'b0;
		clearSel  = 1'b0;
		enableSel = 1'b0;
		moduleSel = 1'b0;
		if (busReq.address == ZCD_CONTROL_ADDR) begin
			ctrlSel = 1'b1;
		end else if (busReq.address == ZCD_IRQ_STATUS_ADDR) begin
			statusSel = 1'b1;
		end else if (busReq.address == ZCD_IRQ_CLEAR_ADDR) begin
			clearSel = 1'b1;
		end else if (busReq.address == ZCD_IRQ_ENABLE_ADDR) begin
			enableSel = 1'b1;
		end else if (busReq.address == ZCD_MODULE_CTRL_ADDR) begin
			moduleSel = 1'b1;
		end
	end

	assign wrStrobe = busReq.write && (busState == ZCD_BUS_ACK);
	assign clearHit = wrStrobe && clearSel && busReq.writedata[ZCD_CROSSING_BIT];

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			ctrl <= '{swEnable: ZCD_CTRL_RESET, invertSelect: ZCD_CTRL_RESET,
				riseIrqEnable: ZCD_CTRL_RESET, fallIrqEnable: ZCD_CTRL_RESET};
		end else if (wrStrobe && ctrlSel) begin
			ctrl.swEnable      <= busReq.writedata[ZCD_SW_ENABLE_BIT];
			ctrl.invertSelect  <= busReq.writedata[ZCD_INVERT_BIT];
			ctrl.riseIrqEnable <= busReq.writedata[ZCD_RISE_EN_BIT];
			ctrl.fallIrqEnable <= busReq.writedata[ZCD_FALL_EN_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			moduleDisable <= ZCD_CTRL_RESET;
		end else if (wrStrobe && moduleSel) begin
			moduleDisable <= busReq.writedata[ZCD_MODULE_DIS_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			crossingIrqEnable <= ZCD_IRQ_RESET;
		end else if (wrStrobe && enableSel) begin
			crossingIrqEnable <= busReq.writedata[ZCD_CROSSING_BIT];
		end
	end

	// Edges flag regardless of sw_enable or sleep, so a polarity write still interrupts
	assign edgeEvent = (risePulse && ctrl.riseIrqEnable)
		|| (fallPulse && ctrl.fallIrqEnable);

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			crossingFlag <= ZCD_IRQ_RESET;
		end else if (edgeEvent) begin
			crossingFlag <= 1'b1;
		end else if (clearHit) begin
			crossingFlag <= 1'b0;
		end
	end

	// Fuse low keeps the detector on; otherwise software enable and disable bit decide
	assign next_detectorEnable = !configFuse
		|| (ctrl.swEnable && !moduleDisable);

	always_comb begin
		next_readdata = 32'h0000_0000;
		if (ctrlSel) begin
			next_readdata[ZCD_SW_ENABLE_BIT] = ctrl.swEnable;
			next_readdata[ZCD_OUTPUT_BIT]    = logicOut;
			next_readdata[ZCD_INVERT_BIT]    = ctrl.invertSelect;
			next_readdata[ZCD_RISE_EN_BIT]   = ctrl.riseIrqEnable;
			next_readdata[ZCD_FALL_EN_BIT]   = ctrl.fallIrqEnable;
		end else if (statusSel) begin
			next_readdata[ZCD_CROSSING_BIT] = crossingFlag;
		end else if (enableSel) begin
			next_readdata[ZCD_CROSSING_BIT] = crossingIrqEnable;
		end else if (moduleSel) begin
			next_readdata[ZCD_MODULE_DIS_BIT] = moduleDisable;
		end
	end

	// Read data is captured while waitrequest is still high, so it stands at the acknowledge edge
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			busRsp <= '{readdata: 32'h0000_0000, waitrequest: 1'b1};
		end else begin
			busRsp.waitrequest <= !((busReq.read || busReq.write) && busState == ZCD_BUS_IDLE);
			if (busReq.read && busState == ZCD_BUS_IDLE) begin
				busRsp.readdata <= next_readdata;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			detectorEnable <= 1'b0;
		end else begin
			detectorEnable <= next_detectorEnable;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			pinForceAnalog <= 1'b0;
		end else begin
			pinForceAnalog <= next_detectorEnable;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			zeroCrossOut <= 1'b0;
		end else begin
			zeroCrossOut <= logicOut;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			crossingIrq <= 1'b0;
		end else begin
			crossingIrq <= crossingFlag && crossingIrqEnable;
		end
	end

	assign avs_readdata    = busRsp.readdata;
	assign avs_waitrequest = busRsp.waitrequest;

	// Sleep input is accepted but deliberately not used: nothing here stops in sleep
	logic unusedSleep;
	assign unusedSleep = sleepMode;

endmodule // zcd_logic

/* hw/zcd_pkg.sv */
// Package with register map, field positions, reset values and bus types for the zero-cross logic
package zcd_pkg;

	// Printed offset is not a multiple of four, so it is an index; byte address is four times it
	localparam logic [15:0] ZCD_CONTROL_INDEX   = 16'h021f;
	localparam logic [15:0] ZCD_IRQ_STATUS_INDEX = 16'h0220;
	localparam logic [15:0] ZCD_IRQ_CLEAR_INDEX  = 16'h0221;
	localparam logic [15:0] ZCD_IRQ_ENABLE_INDEX = 16'h0222;
	localparam logic [15:0] ZCD_MODULE_CTRL_INDEX = 16'h0223;
	localparam int          ZCD_ADDR_W          = 18;

	localparam logic [ZCD_ADDR_W-1:0] ZCD_CONTROL_ADDR     = {ZCD_CONTROL_INDEX, 2'b00};
	localparam logic [ZCD_ADDR_W-1:0] ZCD_IRQ_STATUS_ADDR  = {ZCD_IRQ_STATUS_INDEX, 2'b00};
	localparam logic [ZCD_ADDR_W-1:0] ZCD_IRQ_CLEAR_ADDR   = {ZCD_IRQ_CLEAR_INDEX, 2'b00};
	localparam logic [ZCD_ADDR_W-1:0] ZCD_IRQ_ENABLE_ADDR  = {ZCD_IRQ_ENABLE_INDEX, 2'b00};
	localparam logic [ZCD_ADDR_W-1:0] ZCD_MODULE_CTRL_ADDR = {ZCD_MODULE_CTRL_INDEX, 2'b00};

	// Control register bit positions
	localparam int ZCD_SW_ENABLE_BIT    = 7;
	localparam int ZCD_OUTPUT_BIT       = 5;
	localparam int ZCD_INVERT_BIT       = 4;
	localparam int ZCD_RISE_EN_BIT      = 1;
	localparam int ZCD_FALL_EN_BIT      = 0;
	// Status, clear and enable layout
	localparam int ZCD_CROSSING_BIT     = 0;
	// Module control layout
	localparam int ZCD_MODULE_DIS_BIT   = 0;

	localparam logic       ZCD_CTRL_RESET   = 1'b0;
	localparam logic       ZCD_IRQ_RESET    = 1'b0;
	localparam logic [1:0] ZCD_SYNC_RESET   = 2'b00;

	typedef struct packed {
		logic [ZCD_ADDR_W-1:0] address;
		logic                  read;
		logic                  write;
		logic [31:0]           writedata;
	} zcd_av_req_s;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} zcd_av_rsp_s;

	typedef struct packed {
		logic swEnable;
		logic invertSelect;
		logic riseIrqEnable;
		logic fallIrqEnable;
	} zcd_ctrl_s;

	typedef enum logic {
		ZCD_BUS_IDLE,
		ZCD_BUS_ACK
	} zcd_bus_state_e;

endpackage
